// ===== rtl/iotsr_defs.vh
// iotsr_defs.vh - offsets, field positions, reset values, timing counts
// assumes: included by the register bank files of this block
`ifndef IOTSR_DEFS_VH
`define IOTSR_DEFS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define IOTSR_ADDR_FIRST_QUALITY   16'h7d01
`define IOTSR_ADDR_FIRST_STATUS    16'h7d02
`define IOTSR_ADDR_SECOND_QUALITY  16'h7d03
`define IOTSR_ADDR_SECOND_STATUS   16'h7d04
`define IOTSR_ADDR_TRIP_QUALITY    16'h7d05
`define IOTSR_ADDR_TRIP_CAUSE      16'h7d06

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IOTSR_DIN_LSB     0
`define IOTSR_DOUT_LSB    6
`define IOTSR_PCM_LSB     9
`define IOTSR_UNAVAIL_BIT 15

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IOTSR_RST_WORD    16'h0000
`define IOTSR_RST_UNAVAIL 16'h8000

// ----------------------------------------------------------------------
// timing: clock period and hold window of the test/reset button
// ----------------------------------------------------------------------
`define IOTSR_CLK_NS      100
`define IOTSR_HOLD_MIN_S  3
`define IOTSR_HOLD_MAX_S  15
// cycles per second first, so the products stay inside 32 bits
`define IOTSR_CYC_PER_S    (1000000000 / `IOTSR_CLK_NS)
`define IOTSR_HOLD_MIN_CYC (`IOTSR_HOLD_MIN_S * `IOTSR_CYC_PER_S)
`define IOTSR_HOLD_MAX_CYC (`IOTSR_HOLD_MAX_S * `IOTSR_CYC_PER_S)

// ----------------------------------------------------------------------
// trip unit families for clearing the trip causes
// ----------------------------------------------------------------------
`define IOTSR_FAM_CLOSE   2'd0
`define IOTSR_FAM_KEY     2'd1
`define IOTSR_FAM_BUTTON  2'd2

`endif

// ===== rtl/iotsr_hold_timer.v
// iotsr_hold_timer.v - measures how long the test/reset button is held
// assumes: button level synchronous to mclk, debounced upstream
`timescale 1ns/10ps
`include "iotsr_defs.vh"

module iotsr_hold_timer #(
    parameter CNT_W   = 28,
    parameter MIN_CYC = `IOTSR_HOLD_MIN_CYC,
    parameter MAX_CYC = `IOTSR_HOLD_MAX_CYC
) (
    input  wire mclk,
    input  wire rst,
    input  wire button,
    output reg  release_ok
);

    reg [CNT_W-1:0] hold_cnt_r;
    reg             over_r;

    // ------------------------------------------------------------------
    // count held cycles; pulse on a release inside the window
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            hold_cnt_r <= {CNT_W{1'b0}};
            over_r     <= 1'b0;
            release_ok <= 1'b0;
        end else begin
            release_ok <= 1'b0;
            if (button) begin
                if (hold_cnt_r >= MAX_CYC[CNT_W-1:0])
                    over_r <= 1'b1;
                else
                    hold_cnt_r <= hold_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                if (hold_cnt_r >= MIN_CYC[CNT_W-1:0] && !over_r)
                    release_ok <= 1'b1;
                hold_cnt_r <= {CNT_W{1'b0}};
                over_r     <= 1'b0;
            end
        end
    end

endmodule

// ===== rtl/iotsr_bank.v
// iotsr_bank.v - read-only i/o and trip status register bank
// assumes: single mclk domain; fieldbus engine gives address and strobes
`timescale 1ns/10ps
`include "iotsr_defs.vh"

module iotsr_bank #(
    parameter DIN_N   = 6,
    parameter DOUT_N  = 3,
    parameter PCM_N   = 2,
    parameter TRIP_N  = 15,
    parameter CNT_W   = 28,
    parameter MIN_CYC = `IOTSR_HOLD_MIN_CYC,
    parameter MAX_CYC = `IOTSR_HOLD_MAX_CYC
) (
    input  wire              mclk,
    input  wire              rst,
    input  wire              rd_en,
    input  wire              wr_en,
    input  wire [15:0]       addr,
    input  wire [15:0]       wr_data,
    output reg  [15:0]       rd_data,
    output reg               rd_valid,
    output reg               rd_err,
    input  wire              first_present,
    input  wire [DIN_N-1:0]  first_din,
    input  wire [DOUT_N-1:0] first_dout,
    input  wire [DIN_N-1:0]  first_din_ok,
    input  wire [DOUT_N-1:0] first_dout_ok,
    input  wire              pcm_present,
    input  wire [PCM_N-1:0]  pcm_out,
    input  wire              second_present,
    input  wire [DIN_N-1:0]  second_din,
    input  wire [DOUT_N-1:0] second_dout,
    input  wire [DIN_N-1:0]  second_din_ok,
    input  wire [DOUT_N-1:0] second_dout_ok,
    input  wire [1:0]        trip_family,
    input  wire [TRIP_N-1:0] trip_event,
    input  wire              breaker_closed,
    input  wire              confirm_key,
    input  wire              test_button,
    output reg  [TRIP_N-1:0] trip_cause
);

    // ------------------------------------------------------------------
    // word assembly
    // ------------------------------------------------------------------
    // builds a status word; bit 15 set when module data is absent
    function [15:0] io_word;
        input             present;
        input [DIN_N-1:0]  din;
        input [DOUT_N-1:0] dout;
        input [PCM_N-1:0]  pcm;
        reg   [15:0]       w;
        begin
            w = `IOTSR_RST_WORD;
            w[`IOTSR_DIN_LSB +: DIN_N]   = din;
            w[`IOTSR_DOUT_LSB +: DOUT_N] = dout;
            w[`IOTSR_PCM_LSB +: PCM_N]   = pcm;
            if (!present)
                w = `IOTSR_RST_UNAVAIL;
            io_word = w;
        end
    endfunction

    wire [15:0] first_status_w;
    wire [15:0] first_quality_w;
    wire [15:0] second_status_w;
    wire [15:0] second_quality_w;
    wire [15:0] trip_word_w;
    wire [15:0] trip_quality_w;
    wire [PCM_N-1:0] pcm_bits;
    wire [PCM_N-1:0] pcm_ok;

    assign pcm_bits = pcm_present ? pcm_out : {PCM_N{1'b0}};
    assign pcm_ok   = {PCM_N{pcm_present & first_present}};

    assign first_status_w = io_word(first_present, first_din,
                                    first_dout, pcm_bits);
    assign first_quality_w = io_word(1'b1,
        first_din_ok & {DIN_N{first_present}},
        first_dout_ok & {DOUT_N{first_present}}, pcm_ok) &
        16'h7fff;
    assign second_status_w = io_word(second_present, second_din,
                                     second_dout,
                                     {PCM_N{1'b0}});
    assign second_quality_w = io_word(1'b1,
        second_din_ok & {DIN_N{second_present}},
        second_dout_ok & {DOUT_N{second_present}},
        {PCM_N{1'b0}}) & 16'h7fff;
    assign trip_word_w    = {1'b0, trip_cause};
    assign trip_quality_w = {1'b0, {TRIP_N{1'b1}}};

    // ------------------------------------------------------------------
    // trip cause clearing
    // ------------------------------------------------------------------
    localparam KS_IDLE    = 3'b001;
    localparam KS_VALID   = 3'b010;
    localparam KS_CONFIRM = 3'b100;

    reg  [2:0] key_state_r;
    reg  [2:0] key_state_nxt;
    reg        key_prev_r;
    reg        closed_prev_r;
    reg        clear_nxt;
    wire       key_press;
    wire       reclose;
    wire       button_ok;

    assign key_press = confirm_key & ~key_prev_r;
    assign reclose   = breaker_closed & ~closed_prev_r;

    iotsr_hold_timer #(
        .CNT_W   (CNT_W),
        .MIN_CYC (MIN_CYC),
        .MAX_CYC (MAX_CYC)
    ) u_hold (
        .mclk       (mclk),
        .rst        (rst),
        .button     (test_button),
        .release_ok (button_ok)
    );

    always @* begin
        key_state_nxt = key_state_r;
        case (key_state_r)
            // only a latched trip can be validated
            KS_IDLE: begin
                if (key_press && trip_family == `IOTSR_FAM_KEY &&
                    |trip_cause)
                    key_state_nxt = KS_VALID;
            end
            KS_VALID: begin
                if (trip_family != `IOTSR_FAM_KEY)
                    key_state_nxt = KS_IDLE;
                else if (key_press)
                    key_state_nxt = KS_CONFIRM;
            end
            KS_CONFIRM: begin
                key_state_nxt = KS_IDLE;
            end
            default: begin
                key_state_nxt = KS_IDLE;
            end
        endcase
    end

    always @* begin
        clear_nxt = 1'b0;
        case (trip_family)
            `IOTSR_FAM_CLOSE:  clear_nxt = reclose;
            `IOTSR_FAM_KEY:    clear_nxt = (key_state_r == KS_CONFIRM);
            `IOTSR_FAM_BUTTON: clear_nxt = button_ok;
            default:           clear_nxt = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // latch of trip causes; a new trip wins over a clear
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            key_state_r   <= KS_IDLE;
            key_prev_r    <= 1'b0;
            closed_prev_r <= 1'b0;
            trip_cause    <= {TRIP_N{1'b0}};
        end else begin
            key_state_r   <= key_state_nxt;
            key_prev_r    <= confirm_key;
            closed_prev_r <= breaker_closed;
            if (clear_nxt)
                trip_cause <= trip_event;
            else
                trip_cause <= trip_cause | trip_event;
        end
    end

    // ------------------------------------------------------------------
    // read port; writes change no word and are answered with rd_err unless rd_en is high in the same cycle
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            rd_data  <= `IOTSR_RST_WORD;
            rd_valid <= 1'b0;
            rd_err   <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            rd_err   <= 1'b0;
            if (rd_en) begin
                case (addr)
                    `IOTSR_ADDR_FIRST_QUALITY:  rd_data <= first_quality_w;
                    `IOTSR_ADDR_FIRST_STATUS:   rd_data <= first_status_w;
                    `IOTSR_ADDR_SECOND_QUALITY: rd_data <= second_quality_w;
                    `IOTSR_ADDR_SECOND_STATUS:  rd_data <= second_status_w;
                    `IOTSR_ADDR_TRIP_QUALITY:   rd_data <= trip_quality_w;
                    `IOTSR_ADDR_TRIP_CAUSE:     rd_data <= trip_word_w;
                    default: begin
                        rd_data <= `IOTSR_RST_WORD;
                        rd_err  <= 1'b1;
                    end
                endcase
            end else if (wr_en) begin
                rd_err <= 1'b1;
            end
        end
    end

    // unused write data: words are read-only
    wire unused_wr = |wr_data;

endmodule

// ===== testbench/iotsr_bank_properties.sv
// iotsr_bank_properties.sv - port, word content and trip latch checks of the status bank
// assumes: bound to iotsr_bank, one mclk domain
`timescale 1ns/10ps
module iotsr_bank_properties #(
    parameter TRIP_N = 15
) (
    input logic              mclk,
    input logic              rst,
    input logic              rd_en,
    input logic              wr_en,
    input logic [15:0]       addr,
    input logic [15:0]       rd_data,
    input logic              rd_valid,
    input logic              rd_err,
    input logic              first_present,
    input logic              second_present,
    input logic [1:0]        trip_family,
    input logic [TRIP_N-1:0] trip_event,
    input logic              breaker_closed,
    input logic [TRIP_N-1:0] trip_cause
);
    // ----
    // checks
    // ----
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence take_rd(a);
        rd_en && addr == a;
    endsequence
    sequence quiet_trip;
        trip_family == 2'h0 && trip_event == 0;
    endsequence
    map_answer_a: assert property (rd_en && addr >= 16'h7d01 &&
        addr <= 16'h7d06 |=> rd_valid && !rd_err) else $error("no answer");
    write_ignored_a: assert property (wr_en && !rd_en |=> rd_err &&
        !rd_valid && $stable(rd_data)) else $error("write acted");
    first_absent_a: assert property (take_rd(16'h7d02) ##0
        !first_present |=> rd_data == 16'h8000) else $error("absent word");
    second_absent_a: assert property (take_rd(16'h7d04) ##0
        !second_present |=> rd_data == 16'h8000) else $error("absent two");
    first_resv_a: assert property (take_rd(16'h7d02) ##0
        first_present |=> rd_data[15:11] == 0) else $error("resv first");
    second_resv_a: assert property (take_rd(16'h7d04) ##0
        second_present |=> rd_data[15:9] == 0) else $error("resv second");
    quality_top_a: assert property (take_rd(16'h7d03) |=>
        !rd_data[15]) else $error("quality top bit");
    trip_latch_a: assert property (|trip_event |=>
        (trip_cause & $past(trip_event)) == $past(trip_event))
        else $error("cause not set");
    reclose_clear_a: assert property (quiet_trip and
        $rose(breaker_closed) |=> trip_cause == 0) else $error("no clear");
    cause_hold_a: assert property (quiet_trip and
        !$rose(breaker_closed) |=> $stable(trip_cause))
        else $error("cause lost");
endmodule
bind iotsr_bank iotsr_bank_properties #(.TRIP_N(TRIP_N)) i_props (
    .mclk, .rst, .rd_en, .wr_en, .addr, .rd_data, .rd_valid, .rd_err,
    .first_present, .second_present, .trip_family, .trip_event,
    .breaker_closed, .trip_cause);

// ===== testbench/iotsr_master.sv
// iotsr_master.sv - fieldbus master model reading the status words
// assumes: bank answers exactly one cycle after a request is taken
`timescale 1ns/10ps
module iotsr_master (
    input  logic        mclk,
    output logic        rd_en = 0,
    output logic        wr_en = 0,
    output logic [15:0] addr = 16'h0000,
    output logic [15:0] wr_data = 16'h0000,
    input  logic [15:0] rd_data,
    input  logic        rd_valid,
    input  logic        rd_err
);
    // ----
    // requests launch at the falling edge, released address inverted
    // ----
    task rd(input [15:0] a, output [15:0] d, output e, output ok);
        @(negedge mclk);
        rd_en = 1;
        addr = a;
        @(negedge mclk);
        rd_en = 0;
        addr = ~a;
        ok = rd_valid | rd_err;
        d = rd_data;
        e = rd_err;
    endtask
    task wr(input [15:0] a, output e);
        @(negedge mclk);
        wr_en = 1;
        addr = a;
        wr_data = 16'hffff;
        @(negedge mclk);
        wr_en = 0;
        addr = ~a;
        wr_data = 16'h0000;
        e = rd_err;
    endtask
endmodule

// ===== testbench/test_io_and_trip_status_registers.sv
// test_io_and_trip_status_registers.sv - self-checking bench of the bank
// assumes: iotsr_master drives the bus side, mclk at 10 MHz
`timescale 1ns/10ps
module test_io_and_trip_status_registers;
    logic        mclk = 0, rst = 1, rd_en, wr_en, rd_valid, rd_err;
    logic [15:0] addr, wr_data, rd_data, d;
    logic        fp = 1, sp = 1, pp = 1, bc = 0, key = 0, btn = 0, e, ok;
    logic [1:0]  fam = 0;
    logic [14:0] trip = 0, tc;
    logic [37:0] io = 0;
    integer      errors = 0, samples_checked = 0, i;
    logic [15:0] rows [8][4] = '{'{16'h7d01, 16'h07b3, 16'hffff, 0},
        '{16'h7d02, 16'h056d, 16'hffff, 0}, '{16'h7d03, 16'h004f,
        16'hffff, 0}, '{16'h7d04, 16'h00d2, 16'hffff, 0}, '{16'h7d05,
        16'h7fff, 16'hffff, 0}, '{16'h7d06, 16'h0000, 16'hffff, 0},
        '{16'h7d00, 0, 16'hffff, 1}, '{16'h7d07, 0, 16'hffff, 1}};
    always #50 mclk = ~mclk;
    iotsr_master i_bus (.mclk, .rd_en, .wr_en, .addr, .wr_data,
        .rd_data, .rd_valid, .rd_err);
    iotsr_bank #(.MIN_CYC(10), .MAX_CYC(40)) i_dut (.mclk, .rst, .rd_en,
        .wr_en, .addr, .wr_data, .rd_data, .rd_valid, .rd_err,
        .first_present(fp), .first_din(io[5:0]), .first_dout(io[8:6]),
        .first_din_ok(io[14:9]), .first_dout_ok(io[17:15]),
        .pcm_present(pp), .pcm_out(io[19:18]), .second_present(sp),
        .second_din(io[25:20]), .second_dout(io[28:26]),
        .second_din_ok(io[34:29]), .second_dout_ok(io[37:35]),
        .trip_family(fam), .trip_event(trip), .breaker_closed(bc),
        .confirm_key(key), .test_button(btn), .trip_cause(tc));
    // ----
    // tasks
    // ----
    task check(input [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task expect_rd(input [15:0] a, exp, m);
        i_bus.rd(a, d, e, ok);
        check({15'h0, ok}, 16'h0001);
        check(d & m, exp);
    endtask
    task pulse(input [14:0] t);
        @(negedge mclk) trip = t;
        @(negedge mclk) trip = 0;
    endtask
    task press;
        @(negedge mclk) key = 1;
        @(negedge mclk) key = 0;
        repeat (2) @(negedge mclk);
    endtask
    task hold(input integer n, input [15:0] exp);
        pulse(15'h0001);
        @(negedge mclk) btn = 1;
        repeat (n) @(negedge mclk);
        btn = 0;
        repeat (3) @(negedge mclk);
        expect_rd(16'h7d06, exp, 16'hffff);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        io = {3'h1, 6'h0f, 3'h3, 6'h12, 2'h2, 3'h6, 6'h33, 3'h5, 6'h2d};
        repeat (16) @(negedge mclk);
        rst = 0;
        check(rd_data, 16'h0000);
        for (i = 0; i < 8; i++) begin
            expect_rd(rows[i][0], rows[i][1], rows[i][2]);
            check({15'h0, e}, rows[i][3]);
        end
        i_bus.wr(16'h7d02, e);
        check({15'h0, e}, 16'h0001);
        expect_rd(16'h7d02, 16'h056d, 16'hffff);
        fp = 0;
        expect_rd(16'h7d02, 16'h8000, 16'hffff);
        expect_rd(16'h7d01, 16'h0000, 16'hffff);
        fp = 1;
        pp = 0;
        expect_rd(16'h7d02, 16'h016d, 16'hffff);
        expect_rd(16'h7d01, 16'h01b3, 16'hffff);
        pp = 1;
        sp = 0;
        expect_rd(16'h7d04, 16'h8000, 16'hffff);
        expect_rd(16'h7d03, 16'h0000, 16'hffff);
        sp = 1;
        pulse(15'h4005);
        check({1'b0, tc}, 16'h4005);
        expect_rd(16'h7d06, 16'h4005, 16'hffff);
        expect_rd(16'h7d06, 16'h4005, 16'hffff);
        bc = 1;
        expect_rd(16'h7d06, 16'h0000, 16'hffff);
        fam = 1;
        press;
        pulse(15'h0002);
        press;
        expect_rd(16'h7d06, 16'h0002, 16'hffff);
        press;
        expect_rd(16'h7d06, 16'h0000, 16'hffff);
        fam = 2;
        hold(5, 16'h0001);
        hold(50, 16'h0001);
        hold(20, 16'h0000);
        hold(9, 16'h0001);
        hold(10, 16'h0000);
        hold(40, 16'h0000);
        hold(41, 16'h0001);
        expect_rd(16'h7d02, 16'h056d, 16'hffff);
        pulse(15'h0100);
        check({1'b0, tc}, 16'h0101);
        rst = 1;
        repeat (2) @(negedge mclk);
        rst = 0;
        check({1'b0, tc}, 16'h0000);
        check(rd_data, 16'h0000);
        expect_rd(16'h7d06, 16'h0000, 16'hffff);
        finish_test;
    end
endmodule
